// [core/bcd_defs.svh]
`ifndef BCD_DEFS_SVH
`define BCD_DEFS_SVH

// ---------------------------------------------------------------------
// Instruction field positions
// ---------------------------------------------------------------------
`define BCD_OP6_HI 13
`define BCD_OP6_LO 8
`define BCD_OP4_LO 10
`define BCD_OP7_LO 7
`define BCD_DEST_BIT 7
`define BCD_FA_HI 6
`define BCD_BIX_HI 9
`define BCD_BIX_LO 7
`define BCD_LIT_HI 7
`define BCD_LPC_HI 6

// ---------------------------------------------------------------------
// Operation code prefixes
// ---------------------------------------------------------------------
`define BCD_OPC_ADDC 6'h3d
`define BCD_OPC_XOR 6'h06
`define BCD_OPC_OR 6'h04
`define BCD_OPC_DECSZ 6'h0b
`define BCD_OPC_INCSZ 6'h0f
`define BCD_OPC_XORL 6'h3a
`define BCD_OPC_SUBL 6'h3c
`define BCD_OPC_BTSC 4'h6
`define BCD_OPC_BTSS 4'h7
`define BCD_OPC_LDPCH 7'h63

// ---------------------------------------------------------------------
// Indirect access addresses and constants
// ---------------------------------------------------------------------
`define BCD_IND0_ADDR 7'h00
`define BCD_IND1_ADDR 7'h01
`define BCD_BYTE_ZERO 8'h00
`define BCD_BYTE_ONE 8'h01
`define BCD_DEST_ACC 1'h0

`endif

// [core/bcd_pkg.sv]
package bcd_pkg;

  typedef enum logic [3:0] {
    BCD_OP_NONE = 4'h0,
    BCD_OP_ADDC = 4'h1,
    BCD_OP_XOR = 4'h2,
    BCD_OP_OR = 4'h3,
    BCD_OP_DECSZ = 4'h4,
    BCD_OP_INCSZ = 4'h5,
    BCD_OP_BTSC = 4'h6,
    BCD_OP_BTSS = 4'h7,
    BCD_OP_XORL = 4'h8,
    BCD_OP_SUBL = 4'h9,
    BCD_OP_LDPCH = 4'ha
  } bcd_op_t;

  typedef enum logic [2:0] {
    BCD_ST_EXEC = 3'h1,
    BCD_ST_IND = 3'h2,
    BCD_ST_NOP = 3'h4
  } bcd_state_t;

endpackage

// [core/bcd_dec_if.sv]
`timescale 1ns/1ps
interface bcd_dec_if;
  import bcd_pkg::*;
  logic [13:0] instr;
  bcd_op_t op;
  logic dest;
  logic [6:0] faddr;
  logic [2:0] bidx;
  logic [7:0] lit;
  logic [7:0] acc;
  logic [7:0] fdat;
  logic cin;
  logic [7:0] res;
  logic c;
  logic dc;
  logic z;
  logic skip;

  modport split (input instr, output op, dest, faddr, bidx, lit);
  modport alu (input op, bidx, lit, acc, fdat, cin,
               output res, c, dc, z, skip);
  modport core (output instr, acc, fdat, cin,
                input op, dest, faddr, bidx, lit, res, c, dc, z, skip);
endinterface

// [core/bcd_field_split.sv]
`timescale 1ns/1ps
`include "bcd_defs.svh"
module bcd_field_split (
  // Decoder fields
  bcd_dec_if.split dif
);
  import bcd_pkg::*;

  function automatic bcd_op_t bcd_decode(input logic [13:0] w);
    logic [5:0] p6;
    logic [3:0] p4;
    logic [6:0] p7;
    p6 = w[`BCD_OP6_HI:`BCD_OP6_LO];
    p4 = w[`BCD_OP6_HI:`BCD_OP4_LO];
    p7 = w[`BCD_OP6_HI:`BCD_OP7_LO];
    if (p6 == `BCD_OPC_ADDC) return BCD_OP_ADDC;
    if (p6 == `BCD_OPC_XOR) return BCD_OP_XOR;
    if (p6 == `BCD_OPC_OR) return BCD_OP_OR;
    if (p6 == `BCD_OPC_DECSZ) return BCD_OP_DECSZ;
    if (p6 == `BCD_OPC_INCSZ) return BCD_OP_INCSZ;
    if (p4 == `BCD_OPC_BTSC) return BCD_OP_BTSC;
    if (p4 == `BCD_OPC_BTSS) return BCD_OP_BTSS;
    if (p6 == `BCD_OPC_XORL) return BCD_OP_XORL;
    if (p6 == `BCD_OPC_SUBL) return BCD_OP_SUBL;
    if (p7 == `BCD_OPC_LDPCH) return BCD_OP_LDPCH;
    return BCD_OP_NONE;
  endfunction

  // ---------------------------------------------------------------
  // Field split
  // ---------------------------------------------------------------
  assign dif.op = bcd_decode(dif.instr); // RQ1
  assign dif.dest = dif.instr[`BCD_DEST_BIT]; // RQ1
  assign dif.faddr = dif.instr[`BCD_FA_HI:0]; // RQ1
  assign dif.bidx = dif.instr[`BCD_BIX_HI:`BCD_BIX_LO]; // RQ7
  assign dif.lit = dif.instr[`BCD_LIT_HI:0]; // RQ9

endmodule // bcd_field_split

// [core/bcd_alu.sv]
`timescale 1ns/1ps
`include "bcd_defs.svh"
module bcd_alu (
  // Operands and results
  bcd_dec_if.alu dif
);
  import bcd_pkg::*;

  // ---------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------
  wire [8:0] add_sum = {1'b0, dif.acc} + {1'b0, dif.fdat}
                       + {8'h00, dif.cin};
  wire [4:0] add_nib = {1'b0, dif.acc[3:0]} + {1'b0, dif.fdat[3:0]}
                       + {4'h0, dif.cin};
  wire [8:0] sub_sum = {1'b0, dif.lit} + {1'b0, ~dif.acc} + 9'h001;
  wire [4:0] sub_nib = {1'b0, dif.lit[3:0]} + {1'b0, ~dif.acc[3:0]}
                       + 5'h01;
  wire [7:0] dec_val = dif.fdat - `BCD_BYTE_ONE;
  wire [7:0] inc_val = dif.fdat + `BCD_BYTE_ONE;
  wire bit_val = dif.fdat[dif.bidx];

  // ---------------------------------------------------------------
  // Result select
  // ---------------------------------------------------------------
  assign dif.res =
    (dif.op == BCD_OP_ADDC) ? add_sum[7:0] : // RQ2
    (dif.op == BCD_OP_XOR) ? (dif.acc ^ dif.fdat) : // RQ3
    (dif.op == BCD_OP_OR) ? (dif.acc | dif.fdat) : // RQ4
    (dif.op == BCD_OP_DECSZ) ? dec_val : // RQ5
    (dif.op == BCD_OP_INCSZ) ? inc_val : // RQ6
    (dif.op == BCD_OP_XORL) ? (dif.lit ^ dif.acc) : // RQ9
    (dif.op == BCD_OP_SUBL) ? sub_sum[7:0] : // RQ10
    dif.fdat;
  assign dif.c = (dif.op == BCD_OP_SUBL) ? sub_sum[8] : add_sum[8];
  assign dif.dc = (dif.op == BCD_OP_SUBL) ? sub_nib[4] : add_nib[4];
  assign dif.z = (dif.res == `BCD_BYTE_ZERO); // RQ15
  assign dif.skip =
    ((dif.op == BCD_OP_DECSZ) && (dec_val == `BCD_BYTE_ZERO)) || // RQ5
    ((dif.op == BCD_OP_INCSZ) && (inc_val == `BCD_BYTE_ZERO)) || // RQ6
    ((dif.op == BCD_OP_BTSC) && !bit_val) || // RQ7
    ((dif.op == BCD_OP_BTSS) && bit_val); // RQ8

endmodule // bcd_alu

// [core/bcd_decoder.sv]
// Behaviour
// RQ1: A file word is a 6-bit code, a destination bit, a 7-bit address.
// RQ2: Code 11 1101 adds acc, file and carry in a cycle; updates c, dc, z.
// RQ3: Code 00 0110 XORs acc with the file in one cycle, touching only z.
// RQ4: Code 00 0100 ORs acc with the file register in one cycle.
// RQ5: Code 00 1011 decrements, skips on zero, 1 or 2 cycles, no flags.
// RQ6: Code 00 1111 increments and skips on zero, 1 or 2 cycles.
// RQ7: Code 01 10 tests the indexed bit, skips when clear, 1 or 2 cycles.
// RQ8: Code 01 11 tests the indexed bit, skips when set, no flag change.
// RQ9: Code 11 1010 XORs the literal into acc in one cycle, updating z.
// RQ10: Code 11 1100 takes acc from the literal in a cycle; c, dc, z.
// RQ11: Pattern 11 0001 1 loads 7 bits into the pc high latch, no flags.
// RQ12: A taken skip costs a second cycle that runs as a no-operation.
// RQ13: Indirect access with pointer top bit set costs one extra cycle.
// RQ14: Byte results go to acc when the destination bit is 0, else file.
// RQ15: Affected zero flag is set for a zero 8-bit result, else cleared.
`timescale 1ns/1ps
`include "bcd_defs.svh"
module bcd_decoder #(
  parameter int INSTR_W = 14,
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Instruction fetch
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  output logic instr_ready,
  // Datapath operands
  input wire logic [DATA_W-1:0] acc_value,
  input wire logic [DATA_W-1:0] file_value,
  input wire logic carry_value,
  input wire logic ptr0_msb,
  input wire logic ptr1_msb,
  // Result and write strobes
  output logic [DATA_W-1:0] result,
  output logic acc_we,
  output logic file_we,
  output logic [ADDR_W-1:0] file_addr,
  // Status flags
  output logic flag_c,
  output logic flag_dc,
  output logic flag_z,
  output logic upd_c,
  output logic upd_dc,
  output logic upd_z,
  // Program counter high latch
  output logic [ADDR_W-1:0] pc_high_latch,
  output logic pc_high_latch_we,
  // Sequencing
  output logic skip_next,
  output logic nop_cycle,
  output logic illegal
);
  import bcd_pkg::*;

  bcd_dec_if dif ();

  bcd_field_split u_split (.dif(dif));

  bcd_alu u_alu (.dif(dif));

  assign dif.instr = instr_word;
  assign dif.acc = acc_value;
  assign dif.fdat = file_value;
  assign dif.cin = carry_value;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire accept = instr_valid && instr_ready;
  wire op_byte = (dif.op == BCD_OP_ADDC) || (dif.op == BCD_OP_XOR) ||
                 (dif.op == BCD_OP_OR) || (dif.op == BCD_OP_DECSZ) ||
                 (dif.op == BCD_OP_INCSZ);
  wire op_bit = (dif.op == BCD_OP_BTSC) || (dif.op == BCD_OP_BTSS);
  wire op_lit_acc = (dif.op == BCD_OP_XORL) || (dif.op == BCD_OP_SUBL);
  wire op_arith = (dif.op == BCD_OP_ADDC) || (dif.op == BCD_OP_SUBL);
  wire op_zero = op_arith || (dif.op == BCD_OP_XOR) ||
                 (dif.op == BCD_OP_OR) || (dif.op == BCD_OP_XORL);
  wire op_ldpch = (dif.op == BCD_OP_LDPCH);
  wire ind_hit =
    (op_byte || op_bit) &&
    (((dif.faddr == `BCD_IND0_ADDR) && ptr0_msb) ||
     ((dif.faddr == `BCD_IND1_ADDR) && ptr1_msb)); // RQ13
  wire to_acc = op_lit_acc ||
                (op_byte && (dif.dest == `BCD_DEST_ACC)); // RQ14
  wire to_file = op_byte && (dif.dest != `BCD_DEST_ACC); // RQ14

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  bcd_state_t state_q;
  bcd_state_t state_d;
  logic skip_pend_q;
  logic skip_pend_d;

  always_comb begin
    state_d = state_q;
    skip_pend_d = skip_pend_q;
    case (state_q)
      BCD_ST_EXEC: begin
        if (accept) begin
          skip_pend_d = dif.skip;
          if (ind_hit) begin
            state_d = BCD_ST_IND; // RQ13
          end else if (dif.skip) begin
            state_d = BCD_ST_NOP; // RQ12
          end
        end
      end
      BCD_ST_IND: begin
        state_d = skip_pend_q ? BCD_ST_NOP : BCD_ST_EXEC; // RQ12
      end
      BCD_ST_NOP: begin
        state_d = BCD_ST_EXEC;
        skip_pend_d = 1'b0;
      end
      default: begin
        state_d = BCD_ST_EXEC;
        skip_pend_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= BCD_ST_EXEC;
      skip_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      skip_pend_q <= skip_pend_d;
    end
  end

  logic ready_q;
  logic nop_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ready_q <= 1'b1;
      nop_q <= 1'b0;
    end else begin
      ready_q <= (state_d == BCD_ST_EXEC);
      nop_q <= (state_q != BCD_ST_EXEC); // RQ12
    end
  end

  // ---------------------------------------------------------------
  // Execute strobes
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] res_q;
  logic acc_we_q;
  logic file_we_q;
  logic [ADDR_W-1:0] faddr_q;
  logic c_q;
  logic dc_q;
  logic z_q;
  logic upd_c_q;
  logic upd_dc_q;
  logic upd_z_q;
  logic skip_q;
  logic ill_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      res_q <= `BCD_BYTE_ZERO;
      faddr_q <= `BCD_IND0_ADDR;
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
    end else if (accept) begin
      res_q <= dif.res;
      faddr_q <= dif.faddr; // RQ1
      c_q <= dif.c; // RQ2
      dc_q <= dif.dc; // RQ10
      z_q <= dif.z; // RQ15
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      acc_we_q <= 1'b0;
      file_we_q <= 1'b0;
      upd_c_q <= 1'b0;
      upd_dc_q <= 1'b0;
      upd_z_q <= 1'b0;
      skip_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      acc_we_q <= accept && to_acc; // RQ14
      file_we_q <= accept && to_file; // RQ14
      upd_c_q <= accept && op_arith; // RQ2
      upd_dc_q <= accept && op_arith; // RQ10
      upd_z_q <= accept && op_zero; // RQ3
      skip_q <= accept && dif.skip; // RQ5
      ill_q <= accept && (dif.op == BCD_OP_NONE);
    end
  end

  logic [ADDR_W-1:0] pch_q;
  logic pch_we_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pch_q <= `BCD_IND0_ADDR;
      pch_we_q <= 1'b0;
    end else begin
      pch_we_q <= accept && op_ldpch; // RQ11
      if (accept && op_ldpch) begin
        pch_q <= dif.lit[`BCD_LPC_HI:0]; // RQ11
      end
    end
  end

  assign instr_ready = ready_q;
  assign nop_cycle = nop_q;
  assign result = res_q;
  assign acc_we = acc_we_q;
  assign file_we = file_we_q;
  assign file_addr = faddr_q;
  assign flag_c = c_q;
  assign flag_dc = dc_q;
  assign flag_z = z_q;
  assign upd_c = upd_c_q;
  assign upd_dc = upd_dc_q;
  assign upd_z = upd_z_q;
  assign pc_high_latch = pch_q;
  assign pc_high_latch_we = pch_we_q;
  assign skip_next = skip_q;
  assign illegal = ill_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire [5:0] p6 = instr_word[`BCD_OP6_HI:`BCD_OP6_LO];
  wire [3:0] p4 = instr_word[`BCD_OP6_HI:`BCD_OP4_LO];
  property p_file_fields;
    accept && op_byte |=> file_addr == $past(instr_word[`BCD_FA_HI:0]);
  endproperty
  a_file_fields: assert property (p_file_fields) // RQ1
    else $error("file address not taken from low bits");
  property p_addc;
    accept && (p6 == `BCD_OPC_ADDC)
      |=> upd_c && upd_dc && upd_z &&
          result == $past(acc_value + file_value +
                          {7'h00, carry_value});
  endproperty
  a_addc: assert property (p_addc) // RQ2
    else $error("add with carry result or flags wrong");
  property p_xor;
    accept && (p6 == `BCD_OPC_XOR)
      |=> upd_z && !upd_c && !upd_dc &&
          result == $past(acc_value ^ file_value);
  endproperty
  a_xor: assert property (p_xor) // RQ3
    else $error("register exclusive-or wrong");
  property p_or_one;
    accept && (p6 == `BCD_OPC_OR) && !ind_hit |=> instr_ready;
  endproperty
  a_or_one: assert property (p_or_one) // RQ4
    else $error("inclusive-or took more than one cycle");
  property p_decsz;
    accept && (p6 == `BCD_OPC_DECSZ) && !ind_hit &&
    (file_value == `BCD_BYTE_ONE)
      |=> skip_next && !instr_ready && !upd_z ##1 instr_ready && nop_cycle;
  endproperty
  a_decsz: assert property (p_decsz) // RQ5
    else $error("decrement skip sequence wrong");
  property p_incsz;
    accept && (p6 == `BCD_OPC_INCSZ) && (file_value != ~`BCD_BYTE_ZERO)
      |=> !skip_next && !upd_c;
  endproperty
  a_incsz: assert property (p_incsz) // RQ6
    else $error("increment skipped on non-zero result");
  property p_btsc;
    accept && (p4 == `BCD_OPC_BTSC)
      |=> skip_next == !$past(file_value[dif.bidx]);
  endproperty
  a_btsc: assert property (p_btsc) // RQ7
    else $error("skip-if-clear decision wrong");
  property p_btss;
    accept && (p4 == `BCD_OPC_BTSS)
      |=> skip_next == $past(file_value[dif.bidx]) && !upd_z && !file_we;
  endproperty
  a_btss: assert property (p_btss) // RQ8
    else $error("skip-if-set decision wrong");
  property p_xorl;
    accept && (p6 == `BCD_OPC_XORL)
      |=> acc_we && upd_z &&
          result == $past(instr_word[`BCD_LIT_HI:0] ^ acc_value);
  endproperty
  a_xorl: assert property (p_xorl) // RQ9
    else $error("literal exclusive-or wrong");
  property p_subl;
    accept && (p6 == `BCD_OPC_SUBL)
      |=> upd_c && upd_dc &&
          result == $past(instr_word[`BCD_LIT_HI:0] - acc_value);
  endproperty
  a_subl: assert property (p_subl) // RQ10
    else $error("literal subtract wrong");
  property p_ldpch;
    accept && (instr_word[`BCD_OP6_HI:`BCD_OP7_LO] == `BCD_OPC_LDPCH)
      |=> pc_high_latch_we && !upd_z &&
          pc_high_latch == $past(instr_word[`BCD_LPC_HI:0]);
  endproperty
  a_ldpch: assert property (p_ldpch) // RQ11
    else $error("high latch load wrong");
  property p_ind;
    accept && ind_hit && !dif.skip
      |=> !instr_ready ##1 instr_ready && nop_cycle;
  endproperty
  a_ind: assert property (p_ind) // RQ13
    else $error("indirect extra cycle missing");
  property p_dest;
    accept && op_byte
      |=> acc_we == !$past(dif.dest) && file_we == $past(dif.dest);
  endproperty
  a_dest: assert property (p_dest) // RQ14
    else $error("destination select wrong");
  property p_zero;
    upd_z |-> flag_z == (result == `BCD_BYTE_ZERO);
  endproperty
  a_zero: assert property (p_zero) // RQ15
    else $error("zero flag disagrees with result");
  c_skip: cover property (accept && dif.skip ##1 skip_next ##1 nop_cycle);
  c_ind: cover property (accept && ind_hit ##2 nop_cycle);
  c_back: cover property (accept ##1 accept);
  c_ldpch: cover property (accept && op_ldpch);

endmodule // bcd_decoder

// [sim/bcd_fetch_model.sv]
`timescale 1ns/1ps
module bcd_fetch_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Fetch handshake
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [13:0] instr_word,
  // Operands offered with the word
  output logic [7:0] acc_value,
  output logic [7:0] file_value,
  output logic carry_value
);
  initial begin
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    acc_value = 8'h00;
    file_value = 8'h00;
    carry_value = 1'b0;
  end

  // ------------------------------------------------------------
  // Offer one word, held until the edge that takes it
  // ------------------------------------------------------------
  task automatic offer(input logic [13:0] w, input logic [7:0] a, f,
                       input logic ci, input int wait_n);
    logic rdy_s;
    rdy_s = 1'b0;
    repeat (wait_n) @(posedge core_clk);
    @(posedge core_clk);
    #1;
    instr_valid = 1'b1;
    instr_word = w;
    acc_value = a;
    file_value = f;
    carry_value = ci;
    while (rdy_s !== 1'b1) begin
      rdy_s = instr_ready;
      @(posedge core_clk);
    end
    #1;
    // Released lines show no stale value
    instr_valid = 1'b0;
    instr_word = ~w;
    acc_value = ~a;
    file_value = ~f;
    carry_value = ~ci;
  endtask
endmodule // bcd_fetch_model

// [sim/test_byte_core_instruction_decoder.sv]
`timescale 1ns/1ps
module test_byte_core_instruction_decoder;
  logic core_clk, reset_n, instr_valid, instr_ready, carry_value;
  logic ptr0_msb, ptr1_msb, acc_we, file_we, flag_c, flag_dc, flag_z;
  logic upd_c, upd_dc, upd_z, pc_high_latch_we, skip_next, nop_cycle;
  logic illegal;
  logic [13:0] instr_word;
  logic [7:0] acc_value, file_value, result;
  logic [6:0] file_addr, pc_high_latch;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  bcd_decoder bcd_decoder_i (.core_clk(core_clk), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .acc_value(acc_value),
    .file_value(file_value), .carry_value(carry_value),
    .ptr0_msb(ptr0_msb), .ptr1_msb(ptr1_msb), .result(result),
    .acc_we(acc_we), .file_we(file_we), .file_addr(file_addr),
    .flag_c(flag_c), .flag_dc(flag_dc), .flag_z(flag_z),
    .upd_c(upd_c), .upd_dc(upd_dc), .upd_z(upd_z),
    .pc_high_latch(pc_high_latch), .pc_high_latch_we(pc_high_latch_we),
    .skip_next(skip_next), .nop_cycle(nop_cycle), .illegal(illegal));

  bcd_fetch_model bcd_fetch_model_i (.core_clk(core_clk),
    .reset_n(reset_n), .instr_ready(instr_ready),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .acc_value(acc_value), .file_value(file_value),
    .carry_value(carry_value));

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // Reporting and compares
  // ------------------------------------------------------------
  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // One word through, answer judged; flags {c,dc,z}, we {acc,file}
  // ------------------------------------------------------------
  task automatic run_op(input logic [13:0] w, input logic [7:0] a, f,
    input logic ci, input logic [7:0] er, input logic [2:0] ef, eu,
    input logic [1:0] ewe, input logic es, input int stalls);
    int n;
    int nops;
    n = 0;
    nops = 0;
    bcd_fetch_model_i.offer(w, a, f, ci, 0);
    if (ewe != 2'b00) chk_byte(result, er);
    chk_bit(acc_we, ewe[1]);
    chk_bit(file_we, ewe[0]);
    if (ewe[0]) chk_byte({1'b0, file_addr}, {1'b0, w[6:0]});
    chk_byte({5'h00, upd_c, upd_dc, upd_z}, {5'h00, eu});
    if (eu[2]) chk_bit(flag_c, ef[2]);
    if (eu[1]) chk_bit(flag_dc, ef[1]);
    if (eu[0]) chk_bit(flag_z, ef[0]);
    chk_bit(skip_next, es);
    chk_bit(illegal, 1'b0);
    while (instr_ready !== 1'b1 && n < 4) begin
      n++;
      @(posedge core_clk);
      #1;
      if (nop_cycle === 1'b1) nops++;
    end
    chk_byte(n[7:0], stalls[7:0]);
    chk_byte(nops[7:0], stalls[7:0]);
  endtask

  task automatic test_illegal();
    bcd_fetch_model_i.offer({6'h07, 1'b1, 7'h10}, 8'h01, 8'h02, 1'b0, 0);
    chk_bit(illegal, 1'b1);
    chk_byte({3'h0, acc_we, file_we, upd_c, upd_dc, upd_z}, 8'h00);
    chk_bit(skip_next | pc_high_latch_we, 1'b0);
    chk_bit(instr_ready, 1'b1);
    @(posedge core_clk);
    #1;
    chk_bit(illegal, 1'b0);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset();
    chk_bit(instr_ready, 1'b1);
    chk_bit(acc_we, 1'b0);
    chk_bit(file_we, 1'b0);
    chk_bit(skip_next, 1'b0);
    chk_byte(result, 8'h00);
    chk_byte({1'b0, pc_high_latch}, 8'h00);
  endtask

  task automatic test_add_carry();
    run_op({6'h3d, 1'b1, 7'h25}, 8'h0f, 8'h01, 1'b1, 8'h11, 3'b010,
           3'b111, 2'b01, 1'b0, 0);
    run_op({6'h3d, 1'b0, 7'h7f}, 8'hff, 8'h00, 1'b1, 8'h00, 3'b111,
           3'b111, 2'b10, 1'b0, 0);
    run_op({6'h3d, 1'b1, 7'h12}, 8'h80, 8'h7f, 1'b0, 8'hff, 3'b000,
           3'b111, 2'b01, 1'b0, 0);
  endtask

  task automatic test_logic();
    run_op({6'h06, 1'b1, 7'h33}, 8'h5a, 8'h5a, 1'b1, 8'h00, 3'b001,
           3'b001, 2'b01, 1'b0, 0);
    run_op({6'h06, 1'b0, 7'h34}, 8'h0f, 8'h01, 1'b0, 8'h0e, 3'b000,
           3'b001, 2'b10, 1'b0, 0);
    run_op({6'h04, 1'b0, 7'h40}, 8'h50, 8'h0a, 1'b0, 8'h5a, 3'b000,
           3'b001, 2'b10, 1'b0, 0);
    run_op({6'h04, 1'b1, 7'h41}, 8'h00, 8'h00, 1'b0, 8'h00, 3'b001,
           3'b001, 2'b01, 1'b0, 0);
  endtask

  task automatic test_skips();
    run_op({6'h0b, 1'b1, 7'h30}, 8'h00, 8'h01, 1'b0, 8'h00, 3'b000,
           3'b000, 2'b01, 1'b1, 1);
    run_op({6'h0b, 1'b0, 7'h31}, 8'h00, 8'h05, 1'b0, 8'h04, 3'b000,
           3'b000, 2'b10, 1'b0, 0);
    run_op({6'h0b, 1'b0, 7'h32}, 8'h00, 8'h00, 1'b0, 8'hff, 3'b000,
           3'b000, 2'b10, 1'b0, 0);
    run_op({6'h0f, 1'b1, 7'h35}, 8'h00, 8'hff, 1'b1, 8'h00, 3'b000,
           3'b000, 2'b01, 1'b1, 1);
    run_op({6'h0f, 1'b0, 7'h36}, 8'h00, 8'h10, 1'b0, 8'h11, 3'b000,
           3'b000, 2'b10, 1'b0, 0);
  endtask

  task automatic test_bits();
    logic [7:0] m;
    for (int b = 0; b < 8; b++) begin
      m = 8'h01 << b;
      run_op({4'h6, b[2:0], 7'h50}, 8'h00, ~m, 1'b0, 8'h00, 3'b000,
             3'b000, 2'b00, 1'b1, 1);
      run_op({4'h6, b[2:0], 7'h51}, 8'h00, m, 1'b0, 8'h00, 3'b000,
             3'b000, 2'b00, 1'b0, 0);
      run_op({4'h7, b[2:0], 7'h52}, 8'h00, m, 1'b0, 8'h00, 3'b000,
             3'b000, 2'b00, 1'b1, 1);
      run_op({4'h7, b[2:0], 7'h53}, 8'h00, ~m, 1'b0, 8'h00, 3'b000,
             3'b000, 2'b00, 1'b0, 0);
    end
  endtask

  task automatic test_literals();
    run_op({6'h3a, 8'hf0}, 8'h0f, 8'h00, 1'b0, 8'hff, 3'b000, 3'b001,
           2'b10, 1'b0, 0);
    run_op({6'h3a, 8'ha5}, 8'ha5, 8'h00, 1'b0, 8'h00, 3'b001, 3'b001,
           2'b10, 1'b0, 0);
    run_op({6'h3c, 8'h10}, 8'h01, 8'h00, 1'b0, 8'h0f, 3'b100, 3'b111,
           2'b10, 1'b0, 0);
    run_op({6'h3c, 8'h05}, 8'h05, 8'h00, 1'b0, 8'h00, 3'b111, 3'b111,
           2'b10, 1'b0, 0);
    run_op({6'h3c, 8'h00}, 8'h01, 8'h00, 1'b1, 8'hff, 3'b000, 3'b111,
           2'b10, 1'b0, 0);
  endtask

  task automatic test_latch();
    bcd_fetch_model_i.offer({7'h63, 7'h55}, 8'h00, 8'h00, 1'b0, 3);
    chk_bit(pc_high_latch_we, 1'b1);
    chk_byte({1'b0, pc_high_latch}, 8'h55);
    chk_byte({5'h00, upd_c, upd_dc, upd_z}, 8'h00);
    run_op({7'h63, 7'h2a}, 8'h00, 8'h00, 1'b0, 8'h00, 3'b000, 3'b000,
           2'b00, 1'b0, 0);
    chk_byte({1'b0, pc_high_latch}, 8'h2a);
    run_op({6'h06, 1'b0, 7'h20}, 8'h01, 8'h02, 1'b0, 8'h03, 3'b000,
           3'b001, 2'b10, 1'b0, 0);
    chk_byte({1'b0, pc_high_latch}, 8'h2a);
  endtask

  task automatic test_indirect();
    ptr0_msb = 1'b1;
    run_op({6'h06, 1'b1, 7'h00}, 8'h5a, 8'h5a, 1'b0, 8'h00, 3'b001,
           3'b001, 2'b01, 1'b0, 1);
    run_op({6'h06, 1'b1, 7'h01}, 8'h5a, 8'h0f, 1'b0, 8'h55, 3'b000,
           3'b001, 2'b01, 1'b0, 0);
    run_op({4'h7, 3'h2, 7'h00}, 8'h00, 8'h00, 1'b0, 8'h00, 3'b000,
           3'b000, 2'b00, 1'b0, 1);
    ptr1_msb = 1'b1;
    run_op({6'h0b, 1'b1, 7'h01}, 8'h00, 8'h01, 1'b0, 8'h00, 3'b000,
           3'b000, 2'b01, 1'b1, 2);
    ptr0_msb = 1'b0;
    ptr1_msb = 1'b0;
    run_op({6'h04, 1'b1, 7'h00}, 8'h01, 8'h02, 1'b0, 8'h03, 3'b000,
           3'b001, 2'b01, 1'b0, 0);
  endtask

  initial begin
    reset_n = 1'b0;
    ptr0_msb = 1'b0;
    ptr1_msb = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    test_reset();
    reset_n = 1'b1;
    test_add_carry();
    test_logic();
    test_skips();
    test_bits();
    test_literals();
    test_latch();
    test_illegal();
    test_indirect();
    final_report();
  end
endmodule // test_byte_core_instruction_decoder
